// *** inc/bsc_defines.vh ***
// Constants for the buck start-up and switching-clock control block
`ifndef BSC_DEFINES_VH
`define BSC_DEFINES_VH

// Time base
`define BSC_CLK_MHZ 125
`define BSC_POD_US 600
`define BSC_MEAS_WIN_NS 100000

// Decoded internal frequency indexes
`define BSC_F500 3'h0
`define BSC_F750 3'h1
`define BSC_F1000 3'h2
`define BSC_F1500 3'h3
`define BSC_F2200 3'h4

// Nominal frequencies in kHz
`define BSC_KHZ_500 500
`define BSC_KHZ_750 750
`define BSC_KHZ_1000 1000
`define BSC_KHZ_1500 1500
`define BSC_KHZ_2200 2200

// External clock decode boundaries in kHz
`define BSC_SYNC_MIN_KHZ 400
`define BSC_SYNC_B1_KHZ 600
`define BSC_SYNC_B2_KHZ 857
`define BSC_SYNC_B3_KHZ 1200
`define BSC_SYNC_B4_KHZ 1810

// Fallback runs at this percentage of the internal frequency
`define BSC_SLOW_PCT 70
`define BSC_PCT_FULL 100

// Consecutive cycles to lock and to ride out a lost clock
`define BSC_LOCK_CYCLES 3'h4
`define BSC_SLOW_CYCLES 3'h4

`endif

// *** hw/bsc_top.v ***
// Start-up sequencer and switching clock selection for a step-down converter
`timescale 1ns/1ps
`include "bsc_defines.vh"
// Functional notes
// - Start-up begins only with enable above threshold and the supply above its lockout level.
// - Loss of the supply lockout comparison disables the device; its 150mV hysteresis lives in the comparator.
// - Enable falling below threshold stops switching and selects the low current state.
// - An unconnected enable input counts as asserted.
// - The bias regulator is turned on first and its rail must pass lockout before the power-on delay.
// - During the power-on delay the mode and sync/select straps are sampled and the loop is initialised.
// - The power-on delay lasts 600us and soft start begins only after it.
// - The frequency-set resistor range decodes to one of five frequencies from 500 to 2200 kHz.
// - A late clock is locked only after four consecutive switching cycles each holding a pulse.
// - Switching follows the external clock while present and the internal oscillator otherwise.
// - A clock present before start-up is measured and decoded to the internal frequency.
// - On loss of the clock the device runs four cycles at 70% frequency, then at nominal frequency.
module bsc_top #(
   parameter POD_CYCLES = `BSC_POD_US * `BSC_CLK_MHZ,
   parameter WIN_NS = `BSC_MEAS_WIN_NS
) (
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Comparators and pins
   input wire enable_above_thr,
   input wire enable_floating,
   input wire input_supply_ok,
   input wire internal_bias_rail_ok,
   input wire sync_or_freq_set_pin,
   input wire [2:0] freq_set_resistor_range,
   input wire [4:0] mode_strap_code,
   // Sequencer outputs
   output reg bias_regulator_en_reg,
   output reg low_current_reg,
   output reg strap_sample_reg,
   output reg loop_init_reg,
   output reg soft_start_go_reg,
   output reg switching_en_reg,
   // Strap and clock results
   output reg [4:0] mode_setting_reg,
   output reg [2:0] freq_index_reg,
   output reg sync_locked_reg,
   output reg slow_fallback_reg,
   output reg switch_tick_reg
);

   localparam WIN_CYCLES = (WIN_NS * `BSC_CLK_MHZ) / 1000;
   // Edge thresholds scale with the window so a shortened window stays consistent
   localparam [31:0] E_MIN = (`BSC_SYNC_MIN_KHZ * WIN_NS) / 1000000;
   localparam [31:0] E_B1 = (`BSC_SYNC_B1_KHZ * WIN_NS) / 1000000;
   localparam [31:0] E_B2 = (`BSC_SYNC_B2_KHZ * WIN_NS) / 1000000;
   localparam [31:0] E_B3 = (`BSC_SYNC_B3_KHZ * WIN_NS) / 1000000;
   localparam [31:0] E_B4 = (`BSC_SYNC_B4_KHZ * WIN_NS) / 1000000;

   localparam [1:0] ST_OFF = 2'h0;
   localparam [1:0] ST_BIAS = 2'h1;
   localparam [1:0] ST_POD = 2'h2;
   localparam [1:0] ST_RUN = 2'h3;

   // Period in core clocks of a frequency index, optionally stretched for 70% frequency
   function [9:0] period_of;
      input [2:0] idx;
      input slow;
      reg [31:0] khz;
      reg [31:0] pct;
      reg [31:0] per;
      begin
         khz = `BSC_KHZ_500;
         pct = slow ? `BSC_SLOW_PCT : `BSC_PCT_FULL;
         if (idx == `BSC_F750) begin
            khz = `BSC_KHZ_750;
         end else if (idx == `BSC_F1000) begin
            khz = `BSC_KHZ_1000;
         end else if (idx == `BSC_F1500) begin
            khz = `BSC_KHZ_1500;
         end else if (idx == `BSC_F2200) begin
            khz = `BSC_KHZ_2200;
         end
         per = (`BSC_CLK_MHZ * 1000 * `BSC_PCT_FULL + khz * pct / 2) / (khz * pct);
         period_of = per[9:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   reg [4:0] sync1_reg;
   reg [4:0] sync2_reg;
   reg [7:0] strap1_reg;
   reg [7:0] strap2_reg;
   reg sync_prev_reg;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
         strap1_reg <= 8'h00;
         strap2_reg <= 8'h00;
         sync_prev_reg <= 1'b0;
      end else begin
         // Straps come from pins too, so they pass the same two stages
         strap1_reg <= {freq_set_resistor_range, mode_strap_code};
         strap2_reg <= strap1_reg;
         sync1_reg <= {sync_or_freq_set_pin, internal_bias_rail_ok, input_supply_ok, enable_floating,
                       enable_above_thr};
         sync2_reg <= sync1_reg;
         sync_prev_reg <= sync2_reg[4];
      end
   end

   wire enable_ok = sync2_reg[0] | sync2_reg[1];
   wire supply_ok = sync2_reg[2];
   wire bias_ok = sync2_reg[3];
   wire sync_edge = sync2_reg[4] & ~sync_prev_reg;
   wire go_ok = enable_ok & supply_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Start-up sequencer
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [19:0] pod_cnt_reg;
   reg [19:0] win_cnt_reg;
   reg [15:0] edge_cnt_reg;

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (go_ok) begin
               state_next = ST_BIAS;
            end
         end
         ST_BIAS: begin
            if (bias_ok) begin
               state_next = ST_POD;
            end
         end
         ST_POD: begin
            if ({12'h000, pod_cnt_reg} == POD_CYCLES - 1) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
      if (!go_ok) begin
         state_next = ST_OFF;
      end
   end

   // Decoded measurement, boundary counts go to the higher frequency
   reg [2:0] meas_idx;
   always @* begin
      meas_idx = `BSC_F500;
      if (edge_cnt_reg >= E_B4) begin
         meas_idx = `BSC_F2200;
      end else if (edge_cnt_reg >= E_B3) begin
         meas_idx = `BSC_F1500;
      end else if (edge_cnt_reg >= E_B2) begin
         meas_idx = `BSC_F1000;
      end else if (edge_cnt_reg >= E_B1) begin
         meas_idx = `BSC_F750;
      end
   end

   // Resistor range codes above the table fall back to the lowest frequency
   wire [2:0] res_idx = (strap2_reg[7:5] > `BSC_F2200) ? `BSC_F500 : strap2_reg[7:5];

   always @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg <= ST_OFF;
         pod_cnt_reg <= 20'h00000;
         win_cnt_reg <= 20'h00000;
         edge_cnt_reg <= 16'h0000;
         bias_regulator_en_reg <= 1'b0;
         low_current_reg <= 1'b1;
         strap_sample_reg <= 1'b0;
         loop_init_reg <= 1'b0;
         soft_start_go_reg <= 1'b0;
         switching_en_reg <= 1'b0;
         mode_setting_reg <= 5'h00;
         freq_index_reg <= `BSC_F500;
      end else begin
         state_reg <= state_next;
         bias_regulator_en_reg <= (state_next != ST_OFF);
         low_current_reg <= (state_next == ST_OFF);
         switching_en_reg <= (state_next == ST_RUN);
         soft_start_go_reg <= (state_reg == ST_POD) && (state_next == ST_RUN);
         strap_sample_reg <= (state_reg == ST_BIAS) && (state_next == ST_POD);
         loop_init_reg <= (state_reg == ST_BIAS) && (state_next == ST_POD);
         if (state_reg == ST_POD) begin
            pod_cnt_reg <= pod_cnt_reg + 20'h00001;
         end else begin
            pod_cnt_reg <= 20'h00000;
         end
         if ((state_reg == ST_BIAS) && (state_next == ST_POD)) begin
            mode_setting_reg <= strap2_reg[4:0];
            win_cnt_reg <= 20'h00000;
            edge_cnt_reg <= 16'h0000;
         end else if ((state_reg == ST_POD) && ({12'h000, win_cnt_reg} < WIN_CYCLES)) begin
            win_cnt_reg <= win_cnt_reg + 20'h00001;
            if (sync_edge && (edge_cnt_reg != 16'hFFFF)) begin
               edge_cnt_reg <= edge_cnt_reg + 16'h0001;
            end
         end
         if ((state_reg == ST_POD) && ({12'h000, win_cnt_reg} == WIN_CYCLES - 1)) begin
            // Clock present before start-up overrides the resistor
            freq_index_reg <= (edge_cnt_reg >= E_MIN) ? meas_idx : res_idx;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Switching clock selection
   reg [9:0] per_cnt_reg;
   reg edge_seen_reg;
   reg [2:0] lock_cnt_reg;
   reg [2:0] slow_cnt_reg;
   // Timeout at the slow period doubles as the first stretched cycle after loss
   wire [9:0] nom_per = period_of(freq_index_reg, 1'b0);
   wire [9:0] slow_per = period_of(freq_index_reg, 1'b1);
   wire [9:0] cur_per = (sync_locked_reg | slow_fallback_reg) ? slow_per : nom_per;
   wire per_done = (per_cnt_reg >= cur_per - 10'h001);
   // Cleared on the exit edge so no tick outlives switching enable
   wire run = (state_reg == ST_RUN) && (state_next == ST_RUN);

   always @(posedge core_clk) begin
      if (sys_rst || !run) begin
         per_cnt_reg <= 10'h000;
         edge_seen_reg <= 1'b0;
         lock_cnt_reg <= 3'h0;
         slow_cnt_reg <= 3'h0;
         sync_locked_reg <= 1'b0;
         slow_fallback_reg <= 1'b0;
         switch_tick_reg <= 1'b0;
      end else if (sync_locked_reg) begin
         switch_tick_reg <= sync_edge | per_done;
         if (sync_edge) begin
            per_cnt_reg <= 10'h000;
         end else if (per_done) begin
            // Missing pulse within a stretched period means the clock is gone
            per_cnt_reg <= 10'h000;
            sync_locked_reg <= 1'b0;
            slow_fallback_reg <= 1'b1;
            slow_cnt_reg <= 3'h1;
            lock_cnt_reg <= 3'h0;
            edge_seen_reg <= 1'b0;
         end else begin
            per_cnt_reg <= per_cnt_reg + 10'h001;
         end
      end else begin
         switch_tick_reg <= per_done;
         if (sync_edge) begin
            edge_seen_reg <= 1'b1;
         end
         if (per_done) begin
            per_cnt_reg <= 10'h000;
            // A boundary edge belongs to the ending cycle only, never to two
            edge_seen_reg <= 1'b0;
            if (edge_seen_reg | sync_edge) begin
               if (lock_cnt_reg == `BSC_LOCK_CYCLES - 3'h1) begin
                  sync_locked_reg <= 1'b1;
                  slow_fallback_reg <= 1'b0;
                  lock_cnt_reg <= 3'h0;
               end else begin
                  lock_cnt_reg <= lock_cnt_reg + 3'h1;
               end
            end else begin
               lock_cnt_reg <= 3'h0;
            end
            if (slow_fallback_reg) begin
               if (slow_cnt_reg == `BSC_SLOW_CYCLES - 3'h1) begin
                  slow_fallback_reg <= 1'b0;
                  slow_cnt_reg <= 3'h0;
               end else begin
                  slow_cnt_reg <= slow_cnt_reg + 3'h1;
               end
            end
         end else begin
            per_cnt_reg <= per_cnt_reg + 10'h001;
         end
      end
   end

endmodule

// *** bench/bsc_sync_src.sv ***
// External clock source model for the sync or frequency-set pin
`timescale 1ns/1ps
module bsc_sync_src (
   // Control
   input wire logic run,
   input wire logic [15:0] half_ns,
   // Pin
   output logic sync_o
);
   logic pin_lvl = 1'b0;
   assign sync_o = pin_lvl;
   // Line rests low between bursts, never at its last level
   always begin
      if (run) begin
         #(half_ns) pin_lvl = 1'b1;
         #(half_ns) pin_lvl = 1'b0;
      end else begin
         #1 pin_lvl = 1'b0;
      end
   end
endmodule

// *** bench/bsc_top_checker.sv ***
// Assertion checker for the start-up and clock control block
`timescale 1ns/1ps
module bsc_top_checker #(
   parameter POD_CYCLES = 75000
) (
   input wire core_clk,
   input wire sys_rst,
   input wire enable_above_thr,
   input wire enable_floating,
   input wire input_supply_ok,
   input wire internal_bias_rail_ok,
   input wire sync_or_freq_set_pin,
   input wire bias_regulator_en_reg,
   input wire low_current_reg,
   input wire strap_sample_reg,
   input wire loop_init_reg,
   input wire soft_start_go_reg,
   input wire switching_en_reg,
   input wire [2:0] freq_index_reg,
   input wire sync_locked_reg,
   input wire slow_fallback_reg,
   input wire switch_tick_reg
);
   logic [31:0] pod_cnt;
   logic [15:0] edge_cnt;
   // Bit 2 mirrors the history stage of the block's edge detector
   logic [2:0] sync_q;
   logic [3:0] slow_ticks;
   always @(posedge core_clk) begin
      sync_q <= {sync_q[1:0], sync_or_freq_set_pin};
      pod_cnt <= strap_sample_reg ? 32'h1 : pod_cnt + 32'h1;
      slow_ticks <= slow_fallback_reg ? slow_ticks + {3'h0, switch_tick_reg} : 4'h0;
      // Edges since the last unlock or start of switching, taken one stage ahead of the block's edge detector
      if (sys_rst || sync_locked_reg || !switching_en_reg) edge_cnt <= 16'h0;
      else edge_cnt <= edge_cnt + {15'h0, sync_q[0] & ~sync_q[1]};
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_strap_pulse;
      loop_init_reg ##1 !strap_sample_reg && !loop_init_reg;
   endsequence
   a_start_gate: assert property ($rose(bias_regulator_en_reg) |-> $past(input_supply_ok, 3)
      && ($past(enable_above_thr, 3) || $past(enable_floating, 3))) else $error("start without enable");
   a_supply_off: assert property ($fell(input_supply_ok) |-> ##[2:5] low_current_reg
      && !bias_regulator_en_reg) else $error("supply loss ignored");
   a_enable_off: assert property ($fell(enable_above_thr) && !enable_floating |-> ##[2:5] low_current_reg
      && !switching_en_reg) else $error("enable loss ignored");
   a_bias_first: assert property ($rose(strap_sample_reg) |-> $past(bias_regulator_en_reg)
      && $past(internal_bias_rail_ok, 3)) else $error("delay before bias rail");
   a_strap_pulse: assert property (strap_sample_reg |-> s_strap_pulse)
      else $error("strap pulse malformed");
   a_pod_length: assert property (soft_start_go_reg |-> pod_cnt == POD_CYCLES && switching_en_reg)
      else $error("power-on delay length wrong");
   a_decode_hold: assert property (switching_en_reg && $past(switching_en_reg) |-> $stable(freq_index_reg))
      else $error("frequency changed in run");
   a_tick_run: assert property (switch_tick_reg |-> switching_en_reg)
      else $error("tick outside run");
   a_lock_edges: assert property ($rose(sync_locked_reg) |-> edge_cnt >= 16'h4)
      else $error("lock with too few edges");
   a_slow_entry: assert property ($rose(slow_fallback_reg) |-> $past(sync_locked_reg) && !sync_locked_reg)
      else $error("fallback without lost lock");
   a_tick_follow: assert property (sync_locked_reg && switching_en_reg && sync_q[1] && !sync_q[2]
      |=> switch_tick_reg || !switching_en_reg) else $error("locked tick missed sync edge");
   a_slow_count: assert property ($fell(slow_fallback_reg) && !sync_locked_reg && switching_en_reg
      |-> slow_ticks == 4'h3) else $error("fallback cycle count wrong");
endmodule
bind bsc_top bsc_top_checker #(.POD_CYCLES(POD_CYCLES)) i_bsc_top_checker (.core_clk(core_clk), .sys_rst(sys_rst),
   .enable_above_thr(enable_above_thr), .enable_floating(enable_floating), .input_supply_ok(input_supply_ok),
   .internal_bias_rail_ok(internal_bias_rail_ok), .sync_or_freq_set_pin(sync_or_freq_set_pin),
   .bias_regulator_en_reg(bias_regulator_en_reg), .low_current_reg(low_current_reg),
   .strap_sample_reg(strap_sample_reg), .loop_init_reg(loop_init_reg), .soft_start_go_reg(soft_start_go_reg),
   .switching_en_reg(switching_en_reg), .freq_index_reg(freq_index_reg), .sync_locked_reg(sync_locked_reg),
   .slow_fallback_reg(slow_fallback_reg), .switch_tick_reg(switch_tick_reg));

// *** bench/bsc_top_tb.sv ***
// Self-checking bench for the start-up and clock control block
`timescale 1ns/1ps
module bsc_top_tb;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic en = 1'b0;
   logic en_flt = 1'b0;
   logic sup = 1'b0;
   logic bias = 1'b0;
   logic srun = 1'b0;
   logic [15:0] half = 16'h3E8;
   logic [15:0] halves[6] = '{16'h3E8, 16'h29B, 16'h1F4, 16'h14D, 16'hE3, 16'h50};
   logic [2:0] fexp[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
   logic [2:0] rng = 3'h0;
   logic [4:0] strap = 5'h0;
   logic sync, bias_en, low_cur, strap_s, loop_i, ss_go, sw_en, locked, slow, tick;
   logic [4:0] mode_s;
   logic [2:0] fidx;
   logic [7:0] notes[$];
   logic [7:0] note;
   logic [31:0] seed = 32'h3F;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int i, k;
   always #4 core_clk = ~core_clk;
   bsc_top #(.POD_CYCLES(3000), .WIN_NS(20000)) i_bsc_top (.core_clk(core_clk), .sys_rst(sys_rst),
      .enable_above_thr(en), .enable_floating(en_flt), .input_supply_ok(sup), .internal_bias_rail_ok(bias),
      .sync_or_freq_set_pin(sync), .freq_set_resistor_range(rng), .mode_strap_code(strap),
      .bias_regulator_en_reg(bias_en), .low_current_reg(low_cur), .strap_sample_reg(strap_s), .loop_init_reg(loop_i),
      .soft_start_go_reg(ss_go), .switching_en_reg(sw_en), .mode_setting_reg(mode_s), .freq_index_reg(fidx),
      .sync_locked_reg(locked), .slow_fallback_reg(slow), .switch_tick_reg(tick));
   bsc_sync_src i_bsc_sync_src (.run(srun), .half_ns(half), .sync_o(sync));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic go_wait();
      for (i = 0; i < 4000 && ss_go !== 1'b1; i++) wt(1);
      wt(1);
   endtask
   // Each soft-start pulse pairs with the oldest pending note
   always @(negedge core_clk) begin
      if (ss_go === 1'b1) begin
         note = (notes.size() > 0) ? notes.pop_front() : 8'hFF;
         chk("mode", {3'h0, mode_s}, {3'h0, note[7:3]});
         chk("freq", {5'h0, fidx}, {5'h0, note[2:0]});
      end
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      wt(5);
      sys_rst = 1'b0;
      en_flt = 1'b1;
      void'(xs());
      strap = seed[4:0];
      wt(20);
      chk("state", {5'h0, low_cur, bias_en, sw_en}, 8'h04);
      sup = 1'b1;
      wt(10);
      chk("state", {5'h0, low_cur, bias_en, sw_en}, 8'h02);
      notes.push_back({strap, 3'h0});
      bias = 1'b1;
      go_wait();
      chk("state", {5'h0, low_cur, bias_en, sw_en}, 8'h03);
      // Late clock near the resistor frequency, then taken away
      srun = 1'b1;
      for (i = 0; i < 2000 && locked !== 1'b1; i++) wt(1);
      chk("lock", {7'h0, locked}, 8'h01);
      srun = 1'b0;
      for (i = 0; i < 800 && slow !== 1'b1; i++) wt(1);
      chk("fallback", {6'h0, locked, slow}, 8'h01);
      wt(1500);
      chk("fallback", {6'h0, locked, slow}, 8'h00);
      en_flt = 1'b0;
      wt(6);
      chk("state", {5'h0, low_cur, bias_en, sw_en}, 8'h04);
      // Starts in pairs: clock present before start, then the resistor alone
      for (k = 0; k < 12; k++) begin
         half = halves[k / 2];
         void'(xs());
         rng = seed[2:0];
         strap = seed[9:5];
         srun = !k[0];
         wt(30);
         if (k[0]) notes.push_back({strap, (rng > 3'h4) ? 3'h0 : rng});
         else notes.push_back({strap, fexp[k / 2]});
         en = 1'b1;
         sup = 1'b1;
         go_wait();
         chk("state", {5'h0, low_cur, bias_en, sw_en}, 8'h03);
         if (k[1]) en = 1'b0;
         else sup = 1'b0;
         wt(6);
         chk("state", {5'h0, low_cur, bias_en, sw_en}, 8'h04);
         srun = 1'b0;
         wt(260);
      end
      give_verdict();
   end
endmodule
